// >>> hw/msc_pkg.sv
package msc_pkg;
    // register offsets
    localparam logic [3:0] REG_CTRL      = 4'h0;
    localparam logic [3:0] REG_POWER     = 4'h1;
    localparam logic [3:0] REG_TUNER     = 4'h2;
    localparam logic [3:0] REG_EVENT     = 4'h3;
    localparam logic [3:0] REG_STATUS    = 4'h4;
    localparam logic [3:0] REG_LIMIT     = 4'h5;
    localparam logic [3:0] REG_SERIN     = 4'h6;
    // control field positions
    localparam int CTRL_HOTPLUG_EN  = 0;
    localparam int CTRL_PRES_INV    = 1;
    localparam int CTRL_RADIO_IGN   = 2;
    localparam int CTRL_RADIO_CMD   = 3;
    localparam int CTRL_SMS_WAKE    = 4;
    localparam int CTRL_TUNER_SER   = 5;
    // event field positions (write one to fire)
    localparam int EVT_SMS          = 0;
    localparam int EVT_DATA         = 1;
    localparam int EVT_CARD_DONE    = 2;
    // status field positions
    localparam int ST_CARD_PRESENT  = 0;
    localparam int ST_CARD_READ     = 1;
    localparam int ST_RADIO_ON      = 2;
    localparam int ST_FLIGHT        = 3;
    localparam int ST_PROX_LIMIT    = 4;
    localparam int ST_FOUR_ANT      = 5;
    localparam int ST_WAKE_BUSY     = 6;
    localparam int ST_SER_BUSY      = 7;
    // reset values
    localparam logic [7:0] CTRL_RESET    = 8'h09;
    localparam logic [7:0] POWER_MAX_RST = 8'hFF;
    localparam logic [7:0] POWER_LIM_RST = 8'h80;
    // timing
    localparam int CLK_HZ           = 125_000_000;
    localparam int WAKE_PULSE_MS    = 1000;
    localparam int WAKE_PULSE_CYC   = CLK_HZ / 1000 * WAKE_PULSE_MS;
    localparam int DEBOUNCE_US      = 1000;
    localparam int DEBOUNCE_CYC     = CLK_HZ / 1_000_000 * DEBOUNCE_US;
    localparam int SER_DIV          = 4;
    // card handling states
    typedef enum logic [1:0] {
        MSC_CARD_IDLE,
        MSC_CARD_READ,
        MSC_CARD_READY
    } msc_card_t;
endpackage : msc_pkg

// >>> hw/msc_sideband.sv
// Added by the designer: the address map and the strobed register port.
`timescale 1ns/1ps
module msc_sideband
    import msc_pkg::*;
#(
    parameter int WAKE_CYCLES = WAKE_PULSE_CYC,
    parameter int DEB_CYCLES  = DEBOUNCE_CYC
) (
    // clock and reset
    input  wire logic       ref_clk,
    input  wire logic       rst_b,
    // register port
    input  wire logic [3:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    // board inputs
    input  wire logic       card_present_in,
    input  wire logic       radio_off_n,
    input  wire logic       proximity_n,
    input  wire logic       antenna_count_strap,
    // board outputs
    output logic            status_lamp_n_o,
    output logic            status_lamp_n_oe,
    output logic            host_wake_n,
    output logic            card_read_req,
    output logic            four_antenna,
    output logic      [7:0] tx_power_cap,
    // tuner parallel bits
    output logic            tuner_out_bit0,
    output logic            tuner_out_bit1,
    output logic            tuner_out_bit2,
    output logic            tuner_out_bit3,
    // tuner serial bus
    output logic            tuner_sclk,
    output logic            tuner_sdata_o,
    output logic            tuner_sdata_oe,
    input  wire logic       tuner_sdata_i
);
    localparam int NIN = 4;
    localparam int DW  = $clog2(DEB_CYCLES + 1);
    localparam int WW  = $clog2(WAKE_CYCLES + 1);

    initial begin
        if (WAKE_CYCLES < 1 || DEB_CYCLES < 1) $error("msc_sideband: counts must be at least one");
    end

    // registers
    logic [7:0]      ctrl_ff;
    logic [7:0]      pmax_ff;
    logic [7:0]      plim_ff;
    logic [7:0]      tuner_ff;
    logic [7:0]      rdata_ff;
    logic [NIN-1:0]  clean_ff;
    logic            strap_done_ff;
    logic [1:0]      settle_ff;
    logic            four_ant_ff;
    msc_card_t       card_ff;
    logic [WW-1:0]   wake_cnt_ff;
    logic [7:0]      pcap_ff;
    logic            lamp_ff;
    logic [3:0]      gpo_ff;
    logic [3:0]      ser_bit_ff;
    logic [1:0]      ser_div_ff;
    logic            ser_busy_ff;
    logic            sclk_ff;
    logic            sdo_ff;
    logic            sdi_ff;

    // raw board inputs, order fixed for the filters below
    wire [NIN-1:0] raw_in = {antenna_count_strap, proximity_n, radio_off_n, card_present_in};

    // three-stage synchroniser and debounce per input
    genvar gi;
    generate
        for (gi = 0; gi < NIN; gi++) begin : g_in
            logic [2:0]    sync_ff;
            logic [DW-1:0] cnt_ff;
            wire           agree  = (sync_ff[1] == sync_ff[2]);
            wire           differ = agree && (sync_ff[2] != clean_ff[gi]);
            always_ff @(posedge ref_clk or negedge rst_b) begin
                if (!rst_b) begin
                    sync_ff <= 3'h7;
                    cnt_ff  <= '0;
                end else begin
                    sync_ff <= {sync_ff[1:0], raw_in[gi]};
                    cnt_ff  <= differ ? cnt_ff + 1'b1 : '0;
                end
            end
            // filtered level; reset high matches pull-up idle
            always_ff @(posedge ref_clk or negedge rst_b) begin
                if (!rst_b) clean_ff[gi] <= 1'b1;
                else if (differ && cnt_ff == DW'(DEB_CYCLES - 1)) clean_ff[gi] <= sync_ff[2];
            end
        end
    endgenerate

    // decoded filtered levels
    wire card_lvl  = clean_ff[0];
    wire radio_lvl = clean_ff[1];
    wire prox_lvl  = clean_ff[2];
    wire strap_lvl = clean_ff[3];

    // control bits
    wire hotplug_en = ctrl_ff[CTRL_HOTPLUG_EN];
    wire pres_inv   = ctrl_ff[CTRL_PRES_INV];
    wire radio_ign  = ctrl_ff[CTRL_RADIO_IGN];
    wire radio_cmd  = ctrl_ff[CTRL_RADIO_CMD];
    wire sms_wake   = ctrl_ff[CTRL_SMS_WAKE];
    wire tuner_ser  = ctrl_ff[CTRL_TUNER_SER];

    // register write decode
    wire wr_ctrl  = reg_wr && reg_addr == REG_CTRL;
    wire wr_power = reg_wr && reg_addr == REG_POWER;
    wire wr_tuner = reg_wr && reg_addr == REG_TUNER;
    wire wr_event = reg_wr && reg_addr == REG_EVENT;
    wire wr_limit = reg_wr && reg_addr == REG_LIMIT;

    // card presence and state decisions
    wire card_active = card_lvl ^ pres_inv;
    wire card_in     = hotplug_en ? card_active : 1'b1;
    wire card_gone   = hotplug_en && !card_active;

    // radio and power decisions
    wire radio_pin_ok = radio_ign || radio_lvl;
    wire radio_on     = radio_pin_ok && radio_cmd;
    wire prox_near    = !prox_lvl;
    wire [7:0] nxt_pcap = prox_near ? plim_ff : pmax_ff;

    // wake request sources
    wire sms_req  = wr_event && reg_wdata[EVT_SMS] && sms_wake;
    wire data_req = wr_event && reg_wdata[EVT_DATA];
    wire wake_req = sms_req || data_req;

    // serial tuner transfer start
    wire ser_start = wr_tuner && tuner_ser && !ser_busy_ff;

    // read mux
    wire [7:0] status_w = {ser_busy_ff, (wake_cnt_ff != '0), four_ant_ff, prox_near,
                           !radio_on, radio_on, card_ff == MSC_CARD_READY, card_in};
    wire [7:0] nxt_rdata =
        (reg_addr == REG_CTRL)   ? ctrl_ff  :
        (reg_addr == REG_POWER)  ? pmax_ff  :
        (reg_addr == REG_TUNER)  ? tuner_ff :
        (reg_addr == REG_STATUS) ? status_w :
        (reg_addr == REG_LIMIT)  ? plim_ff  :
        (reg_addr == REG_SERIN)  ? {7'h00, sdi_ff} : 8'h00;

    // configuration registers
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_ff  <= CTRL_RESET;
            pmax_ff  <= POWER_MAX_RST;
            plim_ff  <= POWER_LIM_RST;
            tuner_ff <= 8'h00;
        end else begin
            if (wr_ctrl)  ctrl_ff  <= reg_wdata;
            if (wr_power) pmax_ff  <= reg_wdata;
            if (wr_limit) plim_ff  <= reg_wdata;
            if (wr_tuner) tuner_ff <= reg_wdata;
        end
    end

    // read data, one cycle after the strobe
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) rdata_ff <= 8'h00;
        else        rdata_ff <= reg_rd ? nxt_rdata : 8'h00;
    end

    // strap synchroniser must refill after reset before the level is trusted
    wire strap_steady = (settle_ff == 2'h3) && g_in[3].agree && !g_in[3].differ;

    // antenna strap caught once after reset release and filter settle
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            strap_done_ff <= 1'b0;
            four_ant_ff   <= 1'b0;
            settle_ff     <= 2'h0;
        end else if (settle_ff != 2'h3) begin
            settle_ff <= settle_ff + 1'b1;
        end else if (!strap_done_ff && strap_steady) begin
            strap_done_ff <= 1'b1;
            four_ant_ff   <= !strap_lvl;
        end
    end

    // card state machine
    msc_card_t nxt_card;
    always_comb begin
        nxt_card = card_ff;
        case (card_ff)
            MSC_CARD_IDLE:  if (card_in) nxt_card = MSC_CARD_READ;
            MSC_CARD_READ:  begin
                if (card_gone) nxt_card = MSC_CARD_IDLE;
                else if (wr_event && reg_wdata[EVT_CARD_DONE]) nxt_card = MSC_CARD_READY;
            end
            MSC_CARD_READY: if (card_gone) nxt_card = MSC_CARD_IDLE;
            default:        nxt_card = MSC_CARD_IDLE;
        endcase
    end
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) card_ff <= MSC_CARD_IDLE;
        else        card_ff <= nxt_card;
    end

    // host wake pulse counter
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b)              wake_cnt_ff <= '0;
        else if (wake_req)       wake_cnt_ff <= WW'(WAKE_CYCLES);
        else if (wake_cnt_ff != '0) wake_cnt_ff <= wake_cnt_ff - 1'b1;
    end

    // lamp, power cap and parallel tuner bits
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            lamp_ff <= 1'b0;
            pcap_ff <= POWER_MAX_RST;
            gpo_ff  <= 4'h0;
        end else begin
            lamp_ff <= radio_on;
            pcap_ff <= radio_on ? nxt_pcap : 8'h00;
            gpo_ff  <= tuner_ser ? 4'h0 : tuner_ff[3:0];
        end
    end

    // serial tuner: shifts tuner_ff msb first, clock divided from ref_clk
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            ser_busy_ff <= 1'b0;
            ser_bit_ff  <= 4'h0;
            ser_div_ff  <= 2'h0;
            sclk_ff     <= 1'b0;
            sdo_ff      <= 1'b0;
            sdi_ff      <= 1'b0;
        end else if (ser_start) begin
            ser_busy_ff <= 1'b1;
            ser_bit_ff  <= 4'h8;
            ser_div_ff  <= 2'h0;
            sdo_ff      <= reg_wdata[7];
        end else if (ser_busy_ff) begin
            ser_div_ff <= ser_div_ff + 1'b1;
            if (ser_div_ff == 2'(SER_DIV / 2 - 1)) begin
                sclk_ff <= 1'b1;
                sdi_ff  <= tuner_sdata_i;
            end else if (ser_div_ff == 2'(SER_DIV - 1)) begin
                sclk_ff    <= 1'b0;
                ser_bit_ff <= ser_bit_ff - 1'b1;
                sdo_ff     <= (ser_bit_ff >= 4'h2) ? tuner_ff[3'(ser_bit_ff - 4'h2)] : 1'b0;
                if (ser_bit_ff == 4'h1) ser_busy_ff <= 1'b0;
            end
        end
    end

    // outputs
    assign reg_rdata        = rdata_ff;
    assign status_lamp_n_o  = 1'b0;
    assign status_lamp_n_oe = lamp_ff;
    assign host_wake_n      = (wake_cnt_ff == '0);
    assign card_read_req    = (card_ff == MSC_CARD_READ);
    assign four_antenna     = four_ant_ff;
    assign tx_power_cap     = pcap_ff;
    assign tuner_out_bit0   = gpo_ff[0];
    assign tuner_out_bit1   = gpo_ff[1];
    assign tuner_out_bit2   = gpo_ff[2];
    assign tuner_out_bit3   = gpo_ff[3];
    assign tuner_sclk       = sclk_ff;
    assign tuner_sdata_o    = sdo_ff;
    assign tuner_sdata_oe   = ser_busy_ff;
endmodule : msc_sideband

// >>> testbench/msc_board.sv
`timescale 1ns/1ps
module msc_board (
    // clock and slot switch
    input wire logic ref_clk,
    input wire logic card_inserted,
    output logic     card_present_in,
    // open-drain and two-way pins
    input wire logic status_lamp_n_o,
    input wire logic status_lamp_n_oe,
    input wire logic tuner_sdata_o,
    input wire logic tuner_sdata_oe,
    output logic     lamp_pin,
    output logic     sdata_pin
);
    logic last_ff = 1'b0;
    // detect switch: high with a card, low without
    assign card_present_in = card_inserted;
    // lamp pin pulled up when released
    assign lamp_pin = status_lamp_n_oe ? status_lamp_n_o : 1'b1;
    // released data line shows the inverse of the last driven bit
    assign sdata_pin = tuner_sdata_oe ? tuner_sdata_o : ~last_ff;
    always_ff @(posedge ref_clk) begin
        if (tuner_sdata_oe) last_ff <= tuner_sdata_o;
    end
endmodule : msc_board

// >>> testbench/msc_sideband_asserts.sv
`timescale 1ns/1ps
module msc_sideband_asserts
    import msc_pkg::*;
#(
    parameter int WAKE_CYCLES = WAKE_PULSE_CYC
) (
    // clock, reset and register port
    input wire logic       ref_clk,
    input wire logic       rst_b,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    // board side
    input wire logic       status_lamp_n_o,
    input wire logic       status_lamp_n_oe,
    input wire logic       host_wake_n,
    input wire logic [7:0] tx_power_cap,
    input wire logic       tuner_out_bit0,
    input wire logic       tuner_out_bit1,
    input wire logic       tuner_out_bit2,
    input wire logic       tuner_out_bit3,
    input wire logic       tuner_sclk,
    input wire logic       tuner_sdata_oe
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    // cycles since the last accepted wake request, saturating
    logic sms_en_ff;
    int   cnt_ff;
    wire  ev_wr    = reg_wr && reg_addr == REG_EVENT;
    wire  trig     = ev_wr && (reg_wdata[EVT_DATA] || (reg_wdata[EVT_SMS] && sms_en_ff));
    int   nxt_cnt;
    assign nxt_cnt = trig ? 0 : (cnt_ff > WAKE_CYCLES + 1 ? cnt_ff : cnt_ff + 1);
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            sms_en_ff <= CTRL_RESET[CTRL_SMS_WAKE];
            cnt_ff    <= WAKE_CYCLES + 2;
        end else begin
            if (reg_wr && reg_addr == REG_CTRL) sms_en_ff <= reg_wdata[CTRL_SMS_WAKE];
            cnt_ff <= nxt_cnt;
        end
    end
    chk_wake_held: assert property (cnt_ff < WAKE_CYCLES - 1 |-> !host_wake_n) else $error("wake pulse short");
    chk_wake_idle: assert property (cnt_ff > WAKE_CYCLES |-> host_wake_n) else $error("wake low when idle");
    chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00) else $error("read data not zero");
    chk_unmapped_zero: assert property (reg_rd && reg_addr > 4'h6 |=> reg_rdata == 8'h00) else $error("unmapped read");
    chk_ctrl_readback: assert property (reg_rd && reg_addr == REG_CTRL && $past(reg_wr) && $past(reg_addr) == REG_CTRL
        |=> reg_rdata[5:0] == $past(reg_wdata[5:0], 2)) else $error("control readback");
    chk_lamp_drive_low: assert property (status_lamp_n_o == 1'b0) else $error("lamp drives high");
    chk_radio_off_cap: assert property ($fell(status_lamp_n_oe) |-> tx_power_cap == 8'h00) else $error("cap on");
    chk_serial_frame: assert property ($rose(tuner_sdata_oe) |-> tuner_sdata_oe [*8] ##[23:25] !tuner_sdata_oe)
        else $error("serial frame length");
    chk_parallel_quiet: assert property (tuner_sdata_oe |-> {tuner_out_bit3, tuner_out_bit2, tuner_out_bit1,
        tuner_out_bit0} == 4'h0) else $error("parallel bits in serial mode");
    chk_sclk_frame: assert property (tuner_sclk |-> tuner_sdata_oe) else $error("clock outside frame");
    cover property (!host_wake_n);
    cover property ($rose(tuner_sdata_oe));
    cover property ($fell(status_lamp_n_oe));
endmodule : msc_sideband_asserts

bind msc_sideband msc_sideband_asserts #(.WAKE_CYCLES(WAKE_CYCLES)) u_chk (.ref_clk(ref_clk), .rst_b(rst_b),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .status_lamp_n_o(status_lamp_n_o), .status_lamp_n_oe(status_lamp_n_oe), .host_wake_n(host_wake_n),
    .tx_power_cap(tx_power_cap), .tuner_out_bit0(tuner_out_bit0), .tuner_out_bit1(tuner_out_bit1),
    .tuner_out_bit2(tuner_out_bit2), .tuner_out_bit3(tuner_out_bit3), .tuner_sclk(tuner_sclk),
    .tuner_sdata_oe(tuner_sdata_oe));

// >>> testbench/msc_sideband_test.sv
`timescale 1ns/1ps
module msc_sideband_test
    import msc_pkg::*;
;
    localparam int WK = 20;
    localparam int DB = 4;
    logic       ref_clk, rst_b, reg_wr, reg_rd, ins, radio_off_n, proximity_n, strap, lamp_oe, lamp_o, lamp_pin;
    logic       host_wake_n, card_read_req, four_ant, card_in, b0, b1, b2, b3, sclk, sd_o, sd_oe, sd_pin;
    logic [3:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, cap, sh;
    int         err_count, checks_done, nr, n;
    // board model and design
    msc_board u_board (.ref_clk(ref_clk), .card_inserted(ins), .card_present_in(card_in), .status_lamp_n_o(lamp_o),
        .status_lamp_n_oe(lamp_oe), .tuner_sdata_o(sd_o), .tuner_sdata_oe(sd_oe), .lamp_pin(lamp_pin),
        .sdata_pin(sd_pin));
    msc_sideband #(.WAKE_CYCLES(WK), .DEB_CYCLES(DB)) DUT (.ref_clk(ref_clk), .rst_b(rst_b), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .card_present_in(card_in),
        .radio_off_n(radio_off_n), .proximity_n(proximity_n), .antenna_count_strap(strap),
        .status_lamp_n_o(lamp_o), .status_lamp_n_oe(lamp_oe), .host_wake_n(host_wake_n),
        .card_read_req(card_read_req), .four_antenna(four_ant), .tx_power_cap(cap), .tuner_out_bit0(b0),
        .tuner_out_bit1(b1), .tuner_out_bit2(b2), .tuner_out_bit3(b3), .tuner_sclk(sclk), .tuner_sdata_o(sd_o),
        .tuner_sdata_oe(sd_oe), .tuner_sdata_i(sd_pin));
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end
    // serial tuner bits as the far end samples them
    always @(posedge sclk) begin
        sh <= {sh[6:0], sd_pin};
        nr <= nr + 1;
    end
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        checks_done++;
        if (g !== e) begin
            err_count++;
            $display("unexpected at %0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rdc(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata & m, e);
    endtask : rdc
    task automatic idle(input int c);
        repeat (c) @(posedge ref_clk);
        #1;
    endtask : idle
    task automatic wake(input logic [7:0] e);
        n = 0;
        repeat (WK + 20) begin
            #1;
            if (host_wake_n === 1'b0) n++;
            @(posedge ref_clk);
        end
        chk(8'(n), e);
    endtask : wake
    task automatic summarize();
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : summarize
    initial begin
        repeat (20000) @(posedge ref_clk);
        err_count++;
        summarize();
    end
    initial begin
        {rst_b, reg_wr, reg_rd, reg_addr, reg_wdata, strap, sh, nr, err_count, checks_done} = '0;
        {ins, radio_off_n, proximity_n} = 3'h7;
        repeat (20) @(posedge ref_clk);
        rst_b <= 1'b1;
        idle(DB + 12);
        rdc(REG_CTRL, 8'h3F, CTRL_RESET);
        rdc(REG_POWER, 8'hFF, POWER_MAX_RST);
        rdc(REG_LIMIT, 8'hFF, POWER_LIM_RST);
        rdc(4'h7, 8'hFF, 8'h00);
        chk({7'h00, four_ant}, 8'h01);
        chk({7'h00, card_read_req}, 8'h01);
        wr(REG_EVENT, 8'h04);
        rdc(REG_STATUS, 8'h03, 8'h03);
        ins <= 1'b0;
        idle(DB + 12);
        rdc(REG_STATUS, 8'h03, 8'h00);
        chk({7'h00, card_read_req}, 8'h00);
        wr(REG_CTRL, 8'h0B);
        idle(DB + 12);
        chk({7'h00, card_read_req}, 8'h01);
        wr(REG_EVENT, 8'h04);
        wr(REG_CTRL, 8'h08);
        ins <= 1'b1;
        idle(DB + 12);
        ins <= 1'b0;
        idle(DB + 12);
        rdc(REG_STATUS, 8'h01, 8'h01);
        chk({7'h00, card_read_req}, 8'h00);
        $display("test card done");
        radio_off_n <= 1'b0;
        idle(DB + 12);
        chk({7'h00, lamp_pin}, 8'h01);
        chk(cap, 8'h00);
        rdc(REG_STATUS, 8'h0C, 8'h08);
        wr(REG_CTRL, 8'h0D);
        idle(3);
        chk({7'h00, lamp_pin}, 8'h00);
        radio_off_n <= 1'b1;
        wr(REG_CTRL, 8'h01);
        idle(DB + 12);
        chk({7'h00, lamp_pin}, 8'h01);
        wr(REG_CTRL, CTRL_RESET);
        idle(3);
        chk({7'h00, lamp_pin}, 8'h00);
        proximity_n <= 1'b0;
        idle(DB + 12);
        chk(cap, POWER_LIM_RST);
        wr(REG_LIMIT, 8'h33);
        idle(3);
        chk(cap, 8'h33);
        wr(REG_POWER, 8'hC0);
        proximity_n <= 1'b1;
        idle(DB + 12);
        chk(cap, 8'hC0);
        $display("test radio and power done");
        wr(REG_EVENT, 8'h02);
        wake(8'(WK));
        wr(REG_EVENT, 8'h01);
        wake(8'h00);
        wr(REG_CTRL, 8'h19);
        wr(REG_EVENT, 8'h01);
        wake(8'(WK));
        $display("test wake done");
        wr(REG_TUNER, 8'hA5);
        idle(2);
        chk({4'h0, b3, b2, b1, b0}, 8'h05);
        wr(REG_CTRL, 8'h29);
        n = nr;
        wr(REG_TUNER, 8'h96);
        idle(45);
        chk(8'(nr - n), 8'h08);
        chk(sh, 8'h96);
        $display("test tuner done");
        summarize();
    end
endmodule : msc_sideband_test
